// ===== rtl/spbsc_ctrl.sv
`timescale 1ns/10ps
`include "spbsc_defs.svh"
module spbsc_ctrl #(
   parameter int ADDR_W = `SPBSC_ADDR_W,
   parameter int LANE_W = `SPBSC_LANE_W
) (
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic [ADDR_W-1:0]     word_address,
   input  wire logic                  processor_addr_strobe_n,
   input  wire logic                  controller_addr_strobe_n,
   input  wire logic                  burst_advance_n,
   input  wire logic                  primary_select_n,
   input  wire logic                  second_select,
   input  wire logic                  third_select_n,
   input  wire logic                  global_write_n,
   input  wire logic                  byte_write_gate_n,
   input  wire logic                  lane_a_write_n,
   input  wire logic                  lane_b_write_n,
   input  wire logic                  output_enable_n,
   input  wire logic                  burst_order_select,
   input  wire logic                  sleep_request,
   input  wire logic [2*LANE_W-1:0]   data_in,
   output logic      [2*LANE_W-1:0]   data_out,
   output logic                       data_oe_n,
   output logic      [ADDR_W-1:0]     array_address,
   output logic      [1:0]            array_lane_write,
   output logic      [2*LANE_W-1:0]   array_wdata,
   input  wire logic [2*LANE_W-1:0]   array_rdata,
   output logic                       awake
);
   // ------------------------------------------------------------
   // cycle walk
   // ------------------------------------------------------------
   // edge 0: strobes, selects and external address are taken
   // edge 0: array address and lane strobes also load their flops
   // edge 1: array word lands in the output stage register
   // edge 2: word moves to the output buffer, drive enable follows on the same edge
   // output enable and sleep are taken as levels and registered, so
   // they act one edge late; the trade buys flop-driven outputs
   // a wait state keeps the current word in flight, so the host sees
   // the same word again for every suspended cycle
   // a deselect only idles the state; the counter keeps its place,
   // which is harmless since every start reloads it

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ------------------------------------------------------------
   // sleep and wake-up
   // ------------------------------------------------------------
   // sleep is taken as a level each cycle; wake count holds off access
   logic [1:0] wake_cnt_r;
   logic [1:0] wake_cnt_nxt;
   logic       active;
   assign active       = !sleep_request && (wake_cnt_r == 2'h0);
   assign wake_cnt_nxt = sleep_request ? 2'(`SPBSC_WAKE_CYCLES)
                       : (wake_cnt_r != 2'h0) ? 2'(wake_cnt_r - 2'h1) : 2'h0;
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) wake_cnt_r <= 2'h0;
      else          wake_cnt_r <= wake_cnt_nxt;
   end

   // ------------------------------------------------------------
   // strobe and select decode
   // ------------------------------------------------------------
   logic sel_ok;
   logic p_start;
   logic c_start;
   logic desel;
   logic cont;
   logic lanes_any_n;
   logic wr_decode;
   logic [1:0] lane_wr;
   assign sel_ok  = !primary_select_n && second_select && !third_select_n;
   // primary high masks processor strobe for address pipelining
   assign p_start = !primary_select_n && !processor_addr_strobe_n && sel_ok;
   assign c_start = processor_addr_strobe_n && !controller_addr_strobe_n
                  && sel_ok;
   assign desel   = (primary_select_n && !controller_addr_strobe_n)
                  || (!primary_select_n && !sel_ok
                      && (!processor_addr_strobe_n || !controller_addr_strobe_n));
   assign cont    = controller_addr_strobe_n
                  && (processor_addr_strobe_n || primary_select_n);
   // write decode: global wins, else gate with lanes
   assign lane_wr = !global_write_n ? 2'h3
                  : (!byte_write_gate_n ? {!lane_b_write_n, !lane_a_write_n}
                                        : 2'h0);
   assign wr_decode   = |lane_wr;
   // lanes are ignored on processor strobe edges
   assign lanes_any_n = p_start || !wr_decode;

   // ------------------------------------------------------------
   // burst counter
   // ------------------------------------------------------------
   spbsc_burst_if bif ();
   logic [ADDR_W-1:0] base_addr_r;
   spbsc_pkg::spbsc_op_e op_r;
   spbsc_pkg::spbsc_op_e op_nxt;
   logic step_go;
   // advance ignored on the edge that starts a cycle
   assign step_go   = active && cont && !burst_advance_n && (op_r != spbsc_pkg::SPBSC_IDLE);
   assign bif.load  = active && (p_start || c_start);
   assign bif.step  = step_go;
   assign bif.start = word_address[1:0];
   assign bif.order = burst_order_select;
   spbsc_burst_cnt u_cnt (
      .clk   (core_clk),
      .rst_n (rst_n_r),
      .bus   (bif.cnt)
   );

   // ------------------------------------------------------------
   // operation state
   // ------------------------------------------------------------
   always_comb begin
      op_nxt = op_r;
      if (!active) begin
         op_nxt = op_r;
      end else if (p_start) begin
         op_nxt = spbsc_pkg::SPBSC_READ;
      end else if (c_start) begin
         op_nxt = wr_decode ? spbsc_pkg::SPBSC_WRITE : spbsc_pkg::SPBSC_READ;
      end else if (desel) begin
         op_nxt = spbsc_pkg::SPBSC_IDLE;
      end else if (cont && op_r != spbsc_pkg::SPBSC_IDLE) begin
         op_nxt = wr_decode ? spbsc_pkg::SPBSC_WRITE : spbsc_pkg::SPBSC_READ;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         op_r        <= spbsc_pkg::SPBSC_IDLE;
         base_addr_r <= '0;
      end else begin
         op_r <= op_nxt;
         if (bif.load) base_addr_r <= word_address;
      end
   end

   // ------------------------------------------------------------
   // array access
   // ------------------------------------------------------------
   // address used this cycle: new external on a start, else counter
   logic [ADDR_W-1:0] cur_addr;
   logic              wr_now;
   logic [1:0]        lw_nxt;
   assign cur_addr = {base_addr_r[ADDR_W-1:2], bif.low_addr};
   assign wr_now   = active && !desel && !p_start && wr_decode
                   && (c_start || (cont && op_r != spbsc_pkg::SPBSC_IDLE));
   assign lw_nxt   = wr_now ? lane_wr : 2'h0;
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         array_address    <= '0;
         array_lane_write <= 2'h0;
         array_wdata      <= '0;
      end else begin
         array_address    <= bif.load ? word_address : cur_addr;
         array_lane_write <= lw_nxt;
         if (wr_now) array_wdata <= data_in;
      end
   end

   // ------------------------------------------------------------
   // two-stage read pipe and output drive
   // ------------------------------------------------------------
   logic [2*LANE_W-1:0] rd_stage_r;
   logic                rd_v1_r;
   logic                rd_v2_r;
   logic                rd_now;
   logic                lanes_low_r;
   assign rd_now = active && !desel && lanes_any_n
                 && (bif.load || (op_r != spbsc_pkg::SPBSC_IDLE && cont));
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rd_stage_r  <= '0;
         rd_v1_r     <= 1'b0;
         rd_v2_r     <= 1'b0;
         data_out    <= '0;
         lanes_low_r <= 1'b0;
         awake       <= 1'b0;
      end else begin
         rd_v1_r     <= rd_now;
         rd_stage_r  <= array_rdata;
         rd_v2_r     <= rd_v1_r;
         data_out    <= rd_stage_r;
         lanes_low_r <= !lanes_any_n;
         awake       <= active;
      end
   end
   // drive only while the buffer holds a read word; lanes low force off
   logic drive_ok;
   assign drive_ok = rd_v2_r && lanes_any_n && !lanes_low_r
                   && !sleep_request && !output_enable_n;
   // enable is registered, so async inputs act one edge late here
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) data_oe_n <= 1'b1;
      else          data_oe_n <= !drive_ok;
   end
endmodule

// ===== rtl/spbsc_defs.svh
`ifndef SPBSC_DEFS_SVH
`define SPBSC_DEFS_SVH
// ------------------------------------------------------------
// constants
// ------------------------------------------------------------
`define SPBSC_WAKE_CYCLES   2
`define SPBSC_ADDR_W        18
`define SPBSC_LANE_W        9
`endif

// ===== rtl/spbsc_pkg.sv
package spbsc_pkg;
   typedef enum logic [1:0] {SPBSC_IDLE, SPBSC_READ, SPBSC_WRITE} spbsc_op_e;
endpackage

// ===== rtl/spbsc_burst_if.sv
`timescale 1ns/10ps
// burst counter carrier
interface spbsc_burst_if;
   logic       load;
   logic       step;
   logic [1:0] start;
   logic       order;
   logic [1:0] low_addr;
   modport ctrl (output load, output step, output start, output order, input low_addr);
   modport cnt  (input load, input step, input start, input order, output low_addr);
endinterface

// ===== rtl/spbsc_burst_cnt.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// two-bit burst address counter
// ------------------------------------------------------------
module spbsc_burst_cnt (
   input  wire logic   clk,
   input  wire logic   rst_n,
   spbsc_burst_if.cnt  bus
);
   logic [1:0] start_r;
   logic [1:0] count_r;
   logic [1:0] count_eff;
   // a step shows the next word on the same edge, so that the first
   // continue edge never repeats the start word
   assign count_eff = bus.step ? 2'(count_r + 2'h1) : count_r;
   // linear adds, interleaved xors
   assign bus.low_addr = bus.order ? (start_r ^ count_eff)
                                   : 2'(start_r + count_eff);
   // counter wraps by natural overflow after four
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_r <= 2'h0;
         count_r <= 2'h0;
      end else if (bus.load) begin
         start_r <= bus.start;
         count_r <= 2'h0;
      end else if (bus.step) begin
         count_r <= 2'(count_r + 2'h1);
      end
   end
endmodule

// ===== verification/spbsc_array_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// memory array behind the block
// ------------------------------------------------------------
module spbsc_array_model (
   input  wire logic        core_clk,
   input  wire logic [17:0] array_address,
   input  wire logic [1:0]  array_lane_write,
   input  wire logic [17:0] array_wdata,
   output logic      [17:0] array_rdata
);
   logic [17:0] mem [0:262143];
   // unwritten words read as x, so a stray address never matches
   assign array_rdata = mem[array_address];
   // each lane strobe touches only its own nine bits
   always_ff @(posedge core_clk) begin
      if (array_lane_write[0]) mem[array_address][8:0] <= array_wdata[8:0];
      if (array_lane_write[1]) mem[array_address][17:9] <= array_wdata[17:9];
   end
endmodule

// ===== verification/spbsc_chk.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module spbsc_chk #(parameter int ADDR_W = 18) (
   input wire logic              core_clk,
   input wire logic              arst_n,
   input wire logic [ADDR_W-1:0] word_address,
   input wire logic              processor_addr_strobe_n,
   input wire logic              controller_addr_strobe_n,
   input wire logic              burst_advance_n,
   input wire logic              primary_select_n,
   input wire logic              second_select,
   input wire logic              third_select_n,
   input wire logic              lane_a_write_n,
   input wire logic              output_enable_n,
   input wire logic              sleep_request,
   input wire logic              data_oe_n,
   input wire logic [ADDR_W-1:0] array_address,
   input wire logic [1:0]        array_lane_write,
   input wire logic              awake
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // gate on awake: sleep and wake-up lag the pin by registers
   wire run   = awake && !sleep_request;
   wire idle  = run && processor_addr_strobe_n && controller_addr_strobe_n;
   wire rd_go = run && !processor_addr_strobe_n && !primary_select_n && second_select
                && !third_select_n;
   wire lane  = !lane_a_write_n && processor_addr_strobe_n;
   wire desel = run && !controller_addr_strobe_n && primary_select_n;
   a_sleep_off: assert property (sleep_request [*3] |-> data_oe_n) else $error("pins in sleep");
   a_oe_off: assert property (output_enable_n [*3] |-> data_oe_n) else $error("pins oe off");
   a_lane_off: assert property (lane [*2] |-> data_oe_n) else $error("pins in write");
   a_wake_hold: assert property ($fell(sleep_request) |-> !awake ##1 !awake) else $error("wake");
   a_addr_load: assert property (rd_go |=> array_address == $past(word_address)) else $error("load");
   a_deselect: assert property (desel |=> array_lane_write == 2'h0) else $error("deselect");
   a_wait_hold: assert property (idle && burst_advance_n |=> $stable(array_address)) else $error("wait");
   a_step_next: assert property (idle && !burst_advance_n |=> (array_address >> 2) ==
      ($past(array_address) >> 2) && array_address[1:0] != $past(array_address[1:0])) else $error("step");
   c_write: cover property (!controller_addr_strobe_n && processor_addr_strobe_n && run);
   c_read: cover property (rd_go ##1 idle && !burst_advance_n);
   c_wake: cover property ($fell(sleep_request));
endmodule
bind spbsc_ctrl spbsc_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// ===== verification/tb_top.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module tb_top;
   logic        core_clk, arst_n, processor_addr_strobe_n, controller_addr_strobe_n;
   logic        burst_advance_n, primary_select_n, second_select, third_select_n;
   logic        global_write_n, byte_write_gate_n, lane_a_write_n, lane_b_write_n;
   logic        output_enable_n, burst_order_select, sleep_request, data_oe_n, awake;
   logic [17:0] word_address, data_in, data_out, array_address, array_wdata, array_rdata;
   logic [1:0]  array_lane_write;
   logic [17:0] rd_q [$];
   int          n_errors = 0;
   int          n_checks = 0;
   localparam logic [17:0] D = 18'h2A5A0;
   localparam logic [17:0] N = 18'h0C0F0;
   spbsc_ctrl dut_u (.*);
   spbsc_array_model mem_u (.*);
   // free-running clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // words seen while pins are driven; latency-free comparison
   always @(posedge core_clk) if (data_oe_n === 1'b0) rd_q.push_back(data_out);
   // group {proc, ctrl, select, advance, global write, output enable}
   task automatic put(input logic [5:0] v, input int n);
      {processor_addr_strobe_n, controller_addr_strobe_n, primary_select_n,
       burst_advance_n, global_write_n, output_enable_n} = v;
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // output enable held high for the whole write burst
   task automatic wburst(input logic [17:0] a, d, input logic g, input logic [1:0] ln,
                         input int beats);
      put(6'h3F, 1);
      word_address = a;
      data_in = d;
      {lane_b_write_n, lane_a_write_n} = ln;
      put({4'h9, g, 1'h1}, 1);
      for (int i = 1; i < beats; i++) begin
         data_in = d + 18'(i);
         put({4'hE, g, 1'h1}, 1);
      end
      {lane_b_write_n, lane_a_write_n} = 2'h3;
      put(6'h3F, 3);
      $display("test write burst done");
   endtask
   // burst advance already low on the start edge; the processor strobe must ignore it
   task automatic rburst(input logic [17:0] a, input logic ord, input logic [17:0] e [4]);
      int k;
      k = 0;
      rd_q.delete();
      burst_order_select = ord;
      word_address = a;
      put(6'h12, 1);
      put(6'h3A, 3);
      put(6'h3E, 6);
      for (int i = rd_q.size() - 4; i >= 0; i--)
         if (rd_q[i] === e[0]) k = i;
      for (int j = 0; j < 4; j++)
         chk("read word", e[j], rd_q[k + j]);
      put(6'h3F, 2);
      $display("test read burst done");
   endtask
   // sleep, wake-up count, then a deselect carrying a write
   task automatic sleep_test();
      int n;
      n = 0;
      sleep_request = 1'b1;
      put(6'h3F, 4);
      chk("pins in sleep", 18'h1, {17'h0, data_oe_n});
      chk("awake in sleep", 18'h0, {17'h0, awake});
      sleep_request = 1'b0;
      while (awake !== 1'b1 && n < 10) begin
         put(6'h3F, 1);
         n++;
      end
      chk("wake cycles", 18'h1, {17'h0, n >= 2 && n < 10});
      if (n == 10) conclude();
      put(6'h2D, 1);
      $display("test sleep done");
   endtask
   initial begin
      arst_n = 1'b0;
      {second_select, third_select_n, byte_write_gate_n} = 3'h4;
      {lane_b_write_n, lane_a_write_n, burst_order_select, sleep_request} = 4'hC;
      word_address = 18'h0;
      data_in = 18'h0;
      put(6'h3F, 3);
      arst_n = 1'b1;
      put(6'h3F, 3);
      wburst(18'h00101, D, 1'h0, 2'h3, 4);
      rburst(18'h00101, 1'h0, '{D, D + 18'h1, D + 18'h2, D + 18'h3});
      rburst(18'h00101, 1'h1, '{D, D + 18'h3, D + 18'h2, D + 18'h1});
      sleep_test();
      wburst(18'h00102, N, 1'h1, 2'h2, 2);
      rburst(18'h00102, 1'h0, '{{D[17:9], N[8:0]}, {D[17:9], N[8:0] + 9'h1}, D + 18'h3, D});
      conclude();
   end
endmodule
